//--- acr_pkg.sv
// constants for the converter configuration register group
package acr_pkg;
	localparam logic [14:0] ACR_OFS_INPUT_CFG   = 15'h0011;
	localparam logic [14:0] ACR_OFS_FUSE_LOAD   = 15'h0013;
	localparam logic [14:0] ACR_OFS_PAT_LOW     = 15'h0014;
	localparam logic [14:0] ACR_OFS_PAT_MID     = 15'h0015;
	localparam logic [14:0] ACR_OFS_PAT_HIGH    = 15'h0016;
	localparam logic [7:0]  ACR_RST_INPUT_CFG   = 8'h00;
	localparam logic [7:0]  ACR_RST_FUSE_LOAD   = 8'h00;
	localparam logic [7:0]  ACR_RST_PAT         = 8'h00;
	localparam logic [7:0]  ACR_MASK_INPUT_CFG  = 8'h35;
	localparam logic [7:0]  ACR_MASK_FUSE_LOAD  = 8'h01;
	localparam int          ACR_BIT_SE_A        = 5;
	localparam int          ACR_BIT_SE_B        = 4;
	localparam int          ACR_BIT_LOOP_PDN    = 2;
	localparam int          ACR_BIT_AUTOZERO    = 0;
	localparam int          ACR_BIT_FUSE_LD     = 0;
	localparam int          ACR_SEL_A_LSB       = 2;
	localparam int          ACR_SEL_B_LSB       = 5;
	localparam logic [4:0]  ACR_FRAME_BITS      = 5'h18;
	localparam logic [4:0]  ACR_ADDR_DONE       = 5'h0F;
	localparam logic [4:0]  ACR_DATA_DONE       = 5'h17;
	localparam logic [4:0]  ACR_READ_START      = 5'h10;
	localparam logic [2:0]  ACR_PAT_NORMAL      = 3'h0;
	localparam logic [2:0]  ACR_PAT_RAMP        = 3'h2;
	localparam logic [2:0]  ACR_PAT_CONST       = 3'h3;
	localparam logic [15:0] ACR_RST_SAMPLE      = 16'h0000;
endpackage

//--- acr_pattern_gen.sv
// per-channel test pattern selector between conversion data and patterns
`timescale 1ns/100ps
module acr_pattern_gen
	import acr_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        sample_valid,
	input  wire logic [15:0] conv_data,
	input  wire logic [2:0]  pattern_select,
	input  wire logic [17:0] user_pattern_value,
	output logic      [15:0] data_out
);
	typedef struct packed {
		logic [15:0] ramp;
		logic [15:0] out;
	} acr_pat_state_t;

	acr_pat_state_t s_r;
	acr_pat_state_t s_nxt;

	////////////////////////////////////////////////////////////////////////
	// pattern taken from the top of the 18-bit value: native 16-bit result
	always_comb begin
		s_nxt = s_r;
		if (sample_valid) begin
			unique case (pattern_select)
				ACR_PAT_NORMAL: begin
					s_nxt.out  = conv_data;
					s_nxt.ramp = ACR_RST_SAMPLE;
				end
				ACR_PAT_RAMP: begin
					s_nxt.out  = s_r.ramp;
					s_nxt.ramp = s_r.ramp + user_pattern_value[17:2];
				end
				ACR_PAT_CONST: begin
					s_nxt.out  = user_pattern_value[17:2];
					s_nxt.ramp = ACR_RST_SAMPLE;
				end
				default: begin
					// unused codes give a quiet zero output
					s_nxt.out  = ACR_RST_SAMPLE;
					s_nxt.ramp = ACR_RST_SAMPLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign data_out = s_r.out;

	////////////////////////////////////////////////////////////////////////
	property p_pat_normal;
		@(posedge clock) disable iff (reset)
		sample_valid && pattern_select == ACR_PAT_NORMAL
		|=> data_out == $past(conv_data);
	endproperty
	a_pat_normal: assert property (p_pat_normal)
		else $error("normal mode did not pass conversion data");

	property p_pat_ramp;
		@(posedge clock) disable iff (reset)
		sample_valid && pattern_select == ACR_PAT_RAMP
		##1 sample_valid && pattern_select == ACR_PAT_RAMP
		|=> data_out == $past(data_out) + user_pattern_value[17:2];
	endproperty
	a_pat_ramp: assert property (p_pat_ramp)
		else $error("ramp did not step by the pattern value");
endmodule

//--- acr_config_regs.sv
// configuration register group behind the serial control port
`timescale 1ns/100ps
// Functional notes
// - bit 5 selects channel A single-ended input
// - bit 4 selects channel B single-ended input
// - bit 2 powers sampling loop down, fast only
// - bit 0 autozero, polarity depends on variant
// - fuse load clears earlier serial configuration writes
// - selector picks normal, ramp or constant output
module acr_config_regs
	import acr_pkg::*;
#(
	parameter bit FASTEST_VARIANT = 1'b0
)(
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        sen_n,
	input  wire logic        sclk,
	input  wire logic        sdio_in,
	output logic             sdio_out,
	output logic             sdio_oe,
	input  wire logic        sample_valid,
	input  wire logic [15:0] conv_data_a,
	input  wire logic [15:0] conv_data_b,
	output logic             single_ended_sel_chan_a,
	output logic             single_ended_sel_chan_b,
	output logic             sampling_loop_powerdown,
	output logic             sampling_half_period,
	output logic             autozero_enable,
	output logic             bitmap_load_strobe,
	output logic      [17:0] user_pattern_value,
	output logic      [2:0]  pattern_select_chan_a,
	output logic      [2:0]  pattern_select_chan_b,
	output logic      [15:0] chan_a_out,
	output logic      [15:0] chan_b_out
);
	typedef struct packed {
		logic [1:0]  sen_s;
		logic [2:0]  sclk_s;
		logic [1:0]  sdio_s;
		logic [22:0] shift;
		logic [4:0]  count;
		logic        rd;
		logic [7:0]  tx;
		logic        sdo;
		logic [7:0]  cfg;
		logic [7:0]  fuse;
		logic [7:0]  pat_lo;
		logic [7:0]  pat_mid;
		logic [7:0]  pat_hi;
		logic        reload;
		logic        drv;
	} acr_state_t;

	acr_state_t s_r;
	acr_state_t s_nxt;

	logic        sclk_rise;
	logic        sclk_fall;
	logic        bit_in;
	logic [14:0] rd_addr;
	logic [14:0] wr_addr;
	logic [7:0]  wr_data;
	logic [7:0]  rd_data;
	logic        wr_commit;

	assign sclk_rise = s_r.sclk_s[1] & ~s_r.sclk_s[2];
	assign sclk_fall = ~s_r.sclk_s[1] & s_r.sclk_s[2];
	assign bit_in    = s_r.sdio_s[1];
	assign rd_addr   = {s_r.shift[13:0], bit_in};
	assign wr_addr   = s_r.shift[21:7];
	assign wr_data   = {s_r.shift[6:0], bit_in};
	assign wr_commit = ~s_r.sen_s[1] & sclk_rise & ~s_r.rd &
		(s_r.count == ACR_DATA_DONE);

	////////////////////////////////////////////////////////////////////////
	// read mux; unmapped addresses read zero
	always_comb begin
		unique case (rd_addr)
			ACR_OFS_INPUT_CFG: rd_data = s_r.cfg;
			ACR_OFS_FUSE_LOAD: rd_data = s_r.fuse;
			ACR_OFS_PAT_LOW:   rd_data = s_r.pat_lo;
			ACR_OFS_PAT_MID:   rd_data = s_r.pat_mid;
			ACR_OFS_PAT_HIGH:  rd_data = s_r.pat_hi;
			default:           rd_data = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// frame: read flag, 15 address bits, 8 data bits, msb first
	always_comb begin
		s_nxt        = s_r;
		s_nxt.sen_s  = {s_r.sen_s[0], sen_n};
		s_nxt.sclk_s = {s_r.sclk_s[1:0], sclk};
		s_nxt.sdio_s = {s_r.sdio_s[0], sdio_in};
		s_nxt.reload = 1'b0;
		if (s_r.sen_s[1]) begin
			s_nxt.count = 5'h00;
			s_nxt.rd    = 1'b0;
			s_nxt.drv   = 1'b0;
		end else if (sclk_rise && s_r.count < ACR_FRAME_BITS) begin
			s_nxt.shift = {s_r.shift[21:0], bit_in};
			s_nxt.count = s_r.count + 5'h01;
			if (s_r.count == 5'h00) begin
				s_nxt.rd = bit_in;
			end
			if (s_r.count == ACR_ADDR_DONE && s_r.rd) begin
				s_nxt.tx = rd_data;
			end
			if (s_r.count == ACR_DATA_DONE && !s_r.rd) begin
				unique case (wr_addr)
					ACR_OFS_INPUT_CFG: begin
						s_nxt.cfg = wr_data & ACR_MASK_INPUT_CFG;
					end
					ACR_OFS_FUSE_LOAD: begin
						s_nxt.fuse = wr_data & ACR_MASK_FUSE_LOAD;
						// falling strobe loads the map and wipes prior writes
						if (s_r.fuse[ACR_BIT_FUSE_LD] &&
						    !wr_data[ACR_BIT_FUSE_LD]) begin
							s_nxt.reload  = 1'b1;
							s_nxt.cfg     = ACR_RST_INPUT_CFG;
							s_nxt.pat_lo  = ACR_RST_PAT;
							s_nxt.pat_mid = ACR_RST_PAT;
							s_nxt.pat_hi  = ACR_RST_PAT;
						end
					end
					ACR_OFS_PAT_LOW:  s_nxt.pat_lo  = wr_data;
					ACR_OFS_PAT_MID:  s_nxt.pat_mid = wr_data;
					ACR_OFS_PAT_HIGH: s_nxt.pat_hi  = wr_data;
					default: ;
				endcase
			end
		end else if (sclk_fall && s_r.rd && s_r.count >= ACR_READ_START) begin
			// data changes on the falling edge so the host samples it rising
			s_nxt.sdo = s_r.tx[7];
			s_nxt.tx  = {s_r.tx[6:0], 1'b0};
			// enable rises with the first data bit, never ahead of it
			s_nxt.drv = 1'b1;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			s_r         <= '0;
			s_r.sen_s   <= 2'h3;
			s_r.cfg     <= ACR_RST_INPUT_CFG;
			s_r.fuse    <= ACR_RST_FUSE_LOAD;
			s_r.pat_lo  <= ACR_RST_PAT;
			s_r.pat_mid <= ACR_RST_PAT;
			s_r.pat_hi  <= ACR_RST_PAT;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// decoded controls
	assign sdio_out = s_r.sdo;
	assign sdio_oe  = ~s_r.sen_s[1] & s_r.drv;
	assign single_ended_sel_chan_a = s_r.cfg[ACR_BIT_SE_A];
	assign single_ended_sel_chan_b = s_r.cfg[ACR_BIT_SE_B];
	// the loop only exists on the fastest variant; half period follows it
	assign sampling_loop_powerdown =
		FASTEST_VARIANT & s_r.cfg[ACR_BIT_LOOP_PDN];
	assign sampling_half_period = sampling_loop_powerdown;
	assign autozero_enable = FASTEST_VARIANT ?
		s_r.cfg[ACR_BIT_AUTOZERO] : ~s_r.cfg[ACR_BIT_AUTOZERO];
	assign bitmap_load_strobe = s_r.reload;
	assign user_pattern_value =
		{s_r.pat_hi[1:0], s_r.pat_mid, s_r.pat_lo};
	assign pattern_select_chan_a = s_r.pat_hi[ACR_SEL_A_LSB +: 3];
	assign pattern_select_chan_b = s_r.pat_hi[ACR_SEL_B_LSB +: 3];

	acr_pattern_gen u_pat_a (
		.clock              (clock),
		.reset              (reset),
		.sample_valid       (sample_valid),
		.conv_data          (conv_data_a),
		.pattern_select     (pattern_select_chan_a),
		.user_pattern_value (user_pattern_value),
		.data_out           (chan_a_out)
	);

	acr_pattern_gen u_pat_b (
		.clock              (clock),
		.reset              (reset),
		.sample_valid       (sample_valid),
		.conv_data          (conv_data_b),
		.pattern_select     (pattern_select_chan_b),
		.user_pattern_value (user_pattern_value),
		.data_out           (chan_b_out)
	);

	////////////////////////////////////////////////////////////////////////
	property p_se_follow;
		@(posedge clock) disable iff (reset)
		wr_commit && wr_addr == ACR_OFS_INPUT_CFG
		|=> single_ended_sel_chan_a == $past(wr_data[ACR_BIT_SE_A]) &&
		single_ended_sel_chan_b == $past(wr_data[ACR_BIT_SE_B]);
	endproperty
	a_se_follow: assert property (p_se_follow)
		else $error("input type select does not follow register");

	property p_loop_pdn;
		@(posedge clock) disable iff (reset)
		sampling_loop_powerdown |-> FASTEST_VARIANT && s_r.cfg[2];
	endproperty
	a_loop_pdn: assert property (p_loop_pdn)
		else $error("sampling loop powered down wrongly");

	property p_autozero;
		@(posedge clock) disable iff (reset)
		autozero_enable == (s_r.cfg[0] ^ !FASTEST_VARIANT);
	endproperty
	a_autozero: assert property (p_autozero)
		else $error("autozero polarity wrong for variant");

	property p_fuse_clear;
		@(posedge clock) disable iff (reset)
		$rose(bitmap_load_strobe) |-> s_r.cfg == 8'h00 &&
		user_pattern_value == 18'h0_0000 && $past(s_r.fuse[0]);
	endproperty
	a_fuse_clear: assert property (p_fuse_clear)
		else $error("fuse load did not clear configuration");

	property p_strobe_pulse;
		@(posedge clock) disable iff (reset)
		bitmap_load_strobe |=> !bitmap_load_strobe;
	endproperty
	a_strobe_pulse: assert property (p_strobe_pulse)
		else $error("map load strobe longer than one cycle");

	property p_pattern_join;
		@(posedge clock) disable iff (reset)
		wr_commit && wr_addr == ACR_OFS_PAT_LOW
		|=> user_pattern_value[7:0] == $past(wr_data);
	endproperty
	a_pattern_join: assert property (p_pattern_join)
		else $error("custom pattern assembled wrongly");

	property p_pattern_high;
		@(posedge clock) disable iff (reset)
		wr_commit && wr_addr == ACR_OFS_PAT_HIGH
		|=> user_pattern_value[17:16] == $past(wr_data[1:0]) &&
		pattern_select_chan_a == $past(wr_data[4:2]);
	endproperty
	a_pattern_high: assert property (p_pattern_high)
		else $error("pattern high bits or selector misplaced");
endmodule

//--- acr_serial_host.sv
// serial control port host model that programs the register group
`timescale 1ns/100ps
module acr_serial_host (
	input  wire logic clock,
	output logic      sen_n,
	output logic      sclk,
	output logic      sdio_in,
	input  wire logic sdio_out,
	input  wire logic sdio_oe
);
	initial begin
		sen_n = 1'b1;
		sclk = 1'b0;
		sdio_in = 1'b0;
	end
	// five clocks per sclk phase, the synchroniser needs three
	task automatic waitc(input int n);
		repeat (n) @(negedge clock);
	endtask
	// frame is read flag, 15-bit address, 8 data bits, msb first
	task automatic xfer(input logic rd, input logic [14:0] a,
		input logic [7:0] w, output logic [7:0] q);
		logic [23:0] f;
		f = {rd, a, w};
		q = 8'h00;
		sen_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			sdio_in = f[i];
			waitc(5);
			// an undriven line reads inverted so a late enable shows up
			if (i < 8) q[i] = sdio_oe ? sdio_out : ~sdio_out;
			sclk = 1'b1;
			waitc(5);
			sclk = 1'b0;
		end
		waitc(5);
		sen_n = 1'b1;
		// released line shows the inverse so a stale bit never matches
		sdio_in = ~sdio_in;
		waitc(5);
	endtask
endmodule

//--- tb_top.sv
// self-checking bench for the configuration register group
`timescale 1ns/100ps
module tb_top;
	import acr_pkg::*;
	typedef struct {logic [14:0] a; logic [7:0] w; logic [7:0] r;} acr_row_t;
	logic        clock, reset, sen_n, sclk, sdio_in, sdio_out, sdio_oe;
	logic        sample_valid, single_ended_sel_chan_a;
	logic        single_ended_sel_chan_b, sampling_loop_powerdown;
	logic        sampling_half_period, autozero_enable, bitmap_load_strobe;
	logic [15:0] conv_data_a, conv_data_b, chan_a_out, chan_b_out, q16;
	logic [17:0] user_pattern_value;
	logic [2:0]  pattern_select_chan_a, pattern_select_chan_b;
	logic        f_pdn, f_half, f_az;
	int          n_fail, n_checks, n_strobe;
	acr_row_t    rows [5];
	acr_config_regs #(.FASTEST_VARIANT(1'b0)) DUT (.clock, .reset, .sen_n,
		.sclk, .sdio_in, .sdio_out, .sdio_oe, .sample_valid, .conv_data_a,
		.conv_data_b, .single_ended_sel_chan_a, .single_ended_sel_chan_b,
		.sampling_loop_powerdown, .sampling_half_period, .autozero_enable,
		.bitmap_load_strobe, .user_pattern_value, .pattern_select_chan_a,
		.pattern_select_chan_b, .chan_a_out, .chan_b_out);
	acr_config_regs #(.FASTEST_VARIANT(1'b1)) DUT_fast (.clock, .reset,
		.sen_n, .sclk, .sdio_in, .sdio_out (), .sdio_oe (), .sample_valid,
		.conv_data_a, .conv_data_b, .single_ended_sel_chan_a (),
		.single_ended_sel_chan_b (), .sampling_loop_powerdown (f_pdn),
		.sampling_half_period (f_half), .autozero_enable (f_az),
		.bitmap_load_strobe (), .user_pattern_value (),
		.pattern_select_chan_a (), .pattern_select_chan_b (),
		.chan_a_out (), .chan_b_out ());
	acr_serial_host host (.clock, .sen_n, .sclk, .sdio_in, .sdio_out,
		.sdio_oe);
	always #50 clock = ~clock;
	always @(posedge clock) if (bitmap_load_strobe === 1'b1) n_strobe++;
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [17:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [14:0] a, input logic [7:0] w);
		logic [7:0] q;
		host.xfer(1'b0, a, w, q);
	endtask
	task automatic rd(input logic [14:0] a, input logic [7:0] e);
		logic [7:0] q;
		host.xfer(1'b1, a, 8'h00, q);
		chk("readback", q, e);
	endtask
	task automatic pulse();
		@(negedge clock) sample_valid = 1'b1;
		@(negedge clock) sample_valid = 1'b0;
		@(negedge clock);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		#3_000_000;
		n_fail++;
		tally_and_finish();
	end
	initial begin
		clock = 1'b0;
		reset = 1'b1;
		sample_valid = 1'b0;
		conv_data_a = 16'h0000;
		conv_data_b = 16'h0000;
		n_fail = 0;
		n_checks = 0;
		n_strobe = 0;
		rows = '{'{ACR_OFS_INPUT_CFG, 8'hFF, 8'h35},
			'{ACR_OFS_PAT_LOW, 8'hA5, 8'hA5},
			'{ACR_OFS_PAT_MID, 8'h3C, 8'h3C},
			'{ACR_OFS_PAT_HIGH, 8'hFF, 8'hFF},
			'{15'h0020, 8'hFF, 8'h00}};
		repeat (12) @(negedge clock);
		reset = 1'b0;
		repeat (6) @(negedge clock);
		chk("autozero", autozero_enable, 1'b1);
		chk("az_fast", f_az, 1'b0);
		chk("oe_idle", sdio_oe, 1'b0);
		foreach (rows[i]) begin
			rd(rows[i].a, 8'h00);
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, rows[i].r);
		end
		chk("pattern", user_pattern_value, 18'h3_3CA5);
		chk("sel_a", pattern_select_chan_a, 3'h7);
		chk("sel_b", pattern_select_chan_b, 3'h7);
		chk("se_a", single_ended_sel_chan_a, 1'b1);
		chk("se_b", single_ended_sel_chan_b, 1'b1);
		chk("loop_pdn", sampling_loop_powerdown, 1'b0);
		chk("half", sampling_half_period, 1'b0);
		chk("autozero", autozero_enable, 1'b0);
		chk("pdn_fast", f_pdn, 1'b1);
		chk("half_fast", f_half, 1'b1);
		chk("az_fast", f_az, 1'b1);
		wr(ACR_OFS_INPUT_CFG, 8'h20);
		chk("se_a", single_ended_sel_chan_a, 1'b1);
		chk("se_b", single_ended_sel_chan_b, 1'b0);
		chk("autozero", autozero_enable, 1'b1);
		chk("pdn_fast", f_pdn, 1'b0);
		chk("az_fast", f_az, 1'b0);
		// step code 00100 gives a ramp of one lsb per sample
		wr(ACR_OFS_PAT_LOW, 8'h04);
		wr(ACR_OFS_PAT_MID, 8'h00);
		wr(ACR_OFS_PAT_HIGH, 8'h68);
		pulse();
		q16 = chan_a_out;
		pulse();
		chk("ramp", chan_a_out, q16 + 16'h0001);
		chk("const", chan_b_out, 16'h0001);
		wr(ACR_OFS_PAT_HIGH, 8'h3C);
		pulse();
		chk("unused_a", chan_a_out, 16'h0000);
		chk("unused_b", chan_b_out, 16'h0000);
		wr(ACR_OFS_PAT_HIGH, 8'h00);
		conv_data_a = 16'h1234;
		conv_data_b = 16'hABCD;
		pulse();
		chk("normal_a", chan_a_out, 16'h1234);
		chk("normal_b", chan_b_out, 16'hABCD);
		wr(ACR_OFS_PAT_LOW, 8'h5A);
		// load sequence is one then zero, strobe only on the second
		wr(ACR_OFS_FUSE_LOAD, 8'h01);
		chk("strobe_early", n_strobe, 0);
		wr(ACR_OFS_FUSE_LOAD, 8'h00);
		chk("strobe", n_strobe, 1);
		chk("pattern_clr", user_pattern_value, 18'h0_0000);
		chk("se_a_clr", single_ended_sel_chan_a, 1'b0);
		rd(ACR_OFS_INPUT_CFG, 8'h00);
		rd(ACR_OFS_FUSE_LOAD, 8'h00);
		// mid-run reset must bring every field back to its reset value
		wr(ACR_OFS_INPUT_CFG, 8'h21);
		wr(ACR_OFS_PAT_HIGH, 8'h6B);
		chk("pre_rst_se_a", single_ended_sel_chan_a, 1'b1);
		reset = 1'b1;
		repeat (2) @(negedge clock);
		reset = 1'b0;
		chk("rst_se_a", single_ended_sel_chan_a, 1'b0);
		chk("rst_az", autozero_enable, 1'b1);
		chk("rst_az_fast", f_az, 1'b0);
		chk("rst_pattern", user_pattern_value, 18'h0_0000);
		chk("rst_sel_a", pattern_select_chan_a, 3'h0);
		chk("rst_oe", sdio_oe, 1'b0);
		repeat (6) @(negedge clock);
		rd(ACR_OFS_PAT_HIGH, 8'h00);
		// back to back samples exercise the ramp step check
		wr(ACR_OFS_PAT_LOW, 8'h04);
		wr(ACR_OFS_PAT_HIGH, 8'h08);
		sample_valid = 1'b1;
		repeat (3) @(negedge clock);
		sample_valid = 1'b0;
		@(negedge clock);
		chk("ramp_burst", chan_a_out, 16'h0002);
		chk("normal_burst", chan_b_out, 16'hABCD);
		tally_and_finish();
	end
endmodule
